// ==== src/cmp_pkg.sv ====
/*
  Constants shared by the comparator event logic: register offsets,
  field positions, reset values and mode encodings.
  Assumes a 32-bit Avalon-MM slave with byte addresses.
*/
package cmp_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [5:0] ctrl_off   = 6'h00;
  localparam logic [5:0] refset_off = 6'h04;
  localparam logic [5:0] status_off = 6'h08;
  localparam logic [5:0] mask_off   = 6'h0c;
  localparam logic [5:0] raw_off    = 6'h10;
  localparam logic [5:0] value_off  = 6'h14;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int trig_lsb   = 0;
  localparam int int_lsb    = 4;
  localparam int src_lsb    = 8;
  localparam int inv_bit    = 12;
  localparam int refset_w   = 5;

  localparam logic [31:0] ctrl_rst   = 32'h0000_0000;
  localparam logic [4:0]  refset_rst = 5'h00;
  localparam logic [31:0] unmapped_rd = 32'h0000_0000;

  // ****************************************
  // Event modes, shared by trigger and interrupt
  // ****************************************
  localparam logic [2:0] adc_trigger_off          = 3'h0;
  localparam logic [2:0] adc_trigger_level_high   = 3'h1;
  localparam logic [2:0] adc_trigger_level_low    = 3'h2;
  localparam logic [2:0] adc_trigger_falling_edge = 3'h3;
  localparam logic [2:0] adc_trigger_rising_edge  = 3'h4;
  localparam logic [2:0] adc_trigger_any_edge     = 3'h5;

  // ****************************************
  // Reference source select
  // ****************************************
  localparam logic [1:0] ref_from_own_pin         = 2'h0;
  localparam logic [1:0] ref_from_first_unit_pin  = 2'h1;
  localparam logic [1:0] ref_from_internal_source = 2'h2;

  function automatic logic event_hit(input logic [2:0] mode, input logic cur, input logic prev);
    case (mode)
      adc_trigger_level_high:   event_hit = cur;
      adc_trigger_level_low:    event_hit = !cur;
      adc_trigger_falling_edge: event_hit = prev && !cur;
      adc_trigger_rising_edge:  event_hit = !prev && cur;
      adc_trigger_any_edge:     event_hit = prev != cur;
      default:                  event_hit = 1'b0;
    endcase
  endfunction

  function automatic logic is_level(input logic [2:0] mode);
    is_level = (mode == adc_trigger_level_high) || (mode == adc_trigger_level_low);
  endfunction

endpackage

// ==== src/cmp_sync_if.sv ====
/*
  Carries the synchronised comparator level and its previous sample
  from the synchroniser to the event logic.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
interface cmp_sync_if;
  logic cur;
  logic prev;
  modport src (output cur, output prev);
  modport dst (input  cur, input  prev);
endinterface

// ==== src/cmp_sync.sv ====
/*
  Two-flop synchroniser for the analog comparator result, plus a third
  stage holding the previous synchronised sample for edge detection.
  Assumes the comparator level is asynchronous to mclk.
*/
`timescale 1ns/1ps
module cmp_sync
(
  input  wire logic   mclk,
  input  wire logic   rst_n,
  input  wire logic   cmp_raw,
  cmp_sync_if.src     sync
);

  logic meta_ff;
  logic cur_ff;
  logic prev_ff;
  logic nxt_meta;
  logic nxt_cur;
  logic nxt_prev;

  always_comb
  begin
    nxt_meta = cmp_raw;
    nxt_cur  = meta_ff;
    nxt_prev = cur_ff;
  end

  // First stage read only by the second
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= 1'b0;
      cur_ff  <= 1'b0;
      prev_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      cur_ff  <= nxt_cur;
      prev_ff <= nxt_prev;
    end
  end

  assign sync.cur  = cur_ff;
  assign sync.prev = prev_ff;

  sync_delay_a: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> prev_ff == $past(cur_ff)) else $error("previous sample lost");

endmodule

// ==== src/cmp_event.sv ====
/*
  Comparator event logic: reference select, output polarity, ADC
  trigger and interrupt with mask, raw and masked status.
  Assumes an Avalon-MM master obeying waitrequest, and an analog
  comparator result that is asynchronous to mclk.
*/
`timescale 1ns/1ps
module cmp_event
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        cmp_raw,
  output logic             cmp_pin_out,
  output logic      [1:0]  ref_select,
  output logic      [4:0]  ref_level,
  output logic             ref_enable,
  output logic             adc_trigger,
  output logic             irq
);

  // ****************************************
  // Synchroniser
  // ****************************************
  cmp_sync_if sync_bus ();

  // Two flops ahead of every detector
  cmp_sync u_sync
  (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .cmp_raw (cmp_raw),
    .sync    (sync_bus.src)
  );

  logic cur;
  logic prev;
  assign cur  = sync_bus.cur;
  assign prev = sync_bus.prev;

  // ****************************************
  // State
  // ****************************************
  logic [31:0] ctrl_ff;
  logic [4:0]  refset_ff;
  logic        pend_ff;
  logic        mask_ff;
  logic        trig_ff;
  logic        pin_ff;
  logic        irq_ff;
  logic        ack_ff;
  logic [31:0] rdata_ff;
  logic        wait_ff;
  logic        ref_en_ff;

  logic [31:0] nxt_ctrl;
  logic [4:0]  nxt_refset;
  logic        nxt_pend;
  logic        nxt_mask;
  logic        nxt_trig;
  logic        nxt_pin;
  logic        nxt_irq;
  logic        nxt_ack;
  logic [31:0] nxt_rdata;
  logic        nxt_wait;
  logic        nxt_ref_en;

  logic [2:0] trig_mode;
  logic [2:0] int_mode;
  logic       int_hit;
  logic       clr_wr;
  logic       req;

  assign trig_mode = ctrl_ff[cmp_pkg::trig_lsb +: 3];
  assign int_mode  = ctrl_ff[cmp_pkg::int_lsb +: 3];
  assign int_hit   = cmp_pkg::event_hit(int_mode, cur, prev);
  assign req       = (avs_read || avs_write) && !ack_ff;
  assign clr_wr    = req && avs_write && (avs_address == cmp_pkg::status_off)
                     && avs_byteenable[0] && avs_writedata[0];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    nxt_ctrl   = ctrl_ff;
    nxt_refset = refset_ff;
    nxt_mask   = mask_ff;
    nxt_rdata  = rdata_ff;
    nxt_ack    = req;
    if (req && avs_write)
    begin
      case (avs_address)
        cmp_pkg::ctrl_off:   nxt_ctrl   = merge(ctrl_ff, avs_writedata, avs_byteenable);
        cmp_pkg::refset_off: if (avs_byteenable[0]) nxt_refset = avs_writedata[4:0];
        cmp_pkg::mask_off:   if (avs_byteenable[0]) nxt_mask = avs_writedata[0];
        default:             nxt_mask = mask_ff;
      endcase
    end
    if (req && avs_read)
    begin
      case (avs_address)
        cmp_pkg::ctrl_off:   nxt_rdata = ctrl_ff;
        cmp_pkg::refset_off: nxt_rdata = {27'h0, refset_ff};
        cmp_pkg::status_off: nxt_rdata = {31'h0, pend_ff && mask_ff};
        cmp_pkg::mask_off:   nxt_rdata = {31'h0, mask_ff};
        cmp_pkg::raw_off:    nxt_rdata = {31'h0, pend_ff};
        cmp_pkg::value_off:  nxt_rdata = {31'h0, cur};
        default:             nxt_rdata = cmp_pkg::unmapped_rd;
      endcase
    end
    // Set wins over clear; a held level re-sets it at once
    nxt_pend = int_hit || (pend_ff && !clr_wr);
    // Trigger decided on its own mode, independent of interrupt
    nxt_trig = cmp_pkg::event_hit(trig_mode, cur, prev);
    nxt_pin  = cur ^ ctrl_ff[cmp_pkg::inv_bit];
    nxt_irq  = nxt_pend && nxt_mask;
    // Registered so every output leaves a flop
    nxt_wait   = !nxt_ack;
    nxt_ref_en = nxt_refset != cmp_pkg::refset_rst;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff   <= cmp_pkg::ctrl_rst;
      refset_ff <= cmp_pkg::refset_rst;
      pend_ff   <= 1'b0;
      mask_ff   <= 1'b0;
      trig_ff   <= 1'b0;
      pin_ff    <= 1'b0;
      irq_ff    <= 1'b0;
      ack_ff    <= 1'b0;
      rdata_ff  <= cmp_pkg::unmapped_rd;
      wait_ff   <= 1'b1;
      ref_en_ff <= 1'b0;
    end
    else
    begin
      ctrl_ff   <= nxt_ctrl;
      refset_ff <= nxt_refset;
      pend_ff   <= nxt_pend;
      mask_ff   <= nxt_mask;
      trig_ff   <= nxt_trig;
      pin_ff    <= nxt_pin;
      irq_ff    <= nxt_irq;
      ack_ff    <= nxt_ack;
      rdata_ff  <= nxt_rdata;
      wait_ff   <= nxt_wait;
      ref_en_ff <= nxt_ref_en;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Waitrequest held high until the answer cycle; one wait state per access
  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;
  assign cmp_pin_out     = pin_ff;
  assign ref_select      = ctrl_ff[cmp_pkg::src_lsb +: 2];
  assign ref_level       = refset_ff;
  assign ref_enable      = ref_en_ff;
  assign adc_trigger     = trig_ff;
  assign irq             = irq_ff;

  // ****************************************
  // Checks: trigger
  // ****************************************
  // Edge modes look at the synchronised pair, one cycle before the pulse
  trig_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    trig_mode == cmp_pkg::adc_trigger_off && $stable(trig_mode) |=> !adc_trigger)
    else $error("trigger raised while off");
  trig_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
    trig_mode == cmp_pkg::adc_trigger_level_high |=> adc_trigger == $past(cur))
    else $error("level high trigger wrong");
  trig_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    trig_mode == cmp_pkg::adc_trigger_level_low |=> adc_trigger == !$past(cur))
    else $error("level low trigger wrong");
  trig_rise_a: assert property (@(posedge mclk) disable iff (!rst_n)
    trig_mode == cmp_pkg::adc_trigger_rising_edge && cur && !prev |=> adc_trigger)
    else $error("rising trigger missed");
  trig_fall_a: assert property (@(posedge mclk) disable iff (!rst_n)
    trig_mode == cmp_pkg::adc_trigger_falling_edge && prev && !cur |=> adc_trigger)
    else $error("falling trigger missed");
  trig_any_a: assert property (@(posedge mclk) disable iff (!rst_n)
    trig_mode == cmp_pkg::adc_trigger_any_edge && cur != prev |=> adc_trigger)
    else $error("any edge trigger missed");

  // ****************************************
  // Checks: interrupt
  // ****************************************
  // Set beats clear, so a held level survives a clear in the same cycle
  int_edge_a: assert property (@(posedge mclk) disable iff (!rst_n)
    int_mode == cmp_pkg::adc_trigger_any_edge && cur != prev |=> pend_ff)
    else $error("edge interrupt missed");
  int_rise_a: assert property (@(posedge mclk) disable iff (!rst_n)
    int_mode == cmp_pkg::adc_trigger_rising_edge && cur && !prev |=> pend_ff)
    else $error("rising interrupt missed");
  int_fall_a: assert property (@(posedge mclk) disable iff (!rst_n)
    int_mode == cmp_pkg::adc_trigger_falling_edge && prev && !cur |=> pend_ff)
    else $error("falling interrupt missed");
  int_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
    int_mode == cmp_pkg::adc_trigger_level_low && !cur |=> pend_ff)
    else $error("level interrupt missed");
  int_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
    int_mode == cmp_pkg::adc_trigger_level_high && cur |=> pend_ff)
    else $error("level high interrupt missed");
  int_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    int_mode == cmp_pkg::adc_trigger_off && !pend_ff |=> !pend_ff)
    else $error("interrupt set while off");
  level_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clr_wr && int_hit |=> pend_ff)
    else $error("level interrupt cleared");
  clear_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clr_wr && !int_hit |=> !pend_ff && !irq)
    else $error("clear did not drop");
  mask_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !mask_ff |-> !irq)
    else $error("masked interrupt seen");

  // ****************************************
  // Checks: pin and reference
  // ****************************************
  // Reference outputs are register copies, held against the write that set them
  pin_pol_a: assert property (@(posedge mclk) disable iff (!rst_n)
    1'b1 |=> cmp_pin_out == ($past(cur) ^ $past(ctrl_ff[cmp_pkg::inv_bit])))
    else $error("pin polarity wrong");
  src_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req && avs_write && avs_address == cmp_pkg::ctrl_off && avs_byteenable[1]
    |=> ref_select == $past(avs_writedata[cmp_pkg::src_lsb +: 2])) else $error("reference source wrong");
  ref_lvl_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req && avs_write && avs_address == cmp_pkg::refset_off && avs_byteenable[0]
    |=> ref_level == $past(avs_writedata[cmp_pkg::refset_w-1:0])) else $error("reference level wrong");
  ref_en_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ref_enable == (ref_level != cmp_pkg::refset_rst))
    else $error("reference enable wrong");

  // ****************************************
  // Checks: register bus
  // ****************************************
  // Read data is captured at the request edge and shown at the answer edge
  wait_one_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("answer cycle wrong");
  mask_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req && avs_write && avs_address == cmp_pkg::mask_off && avs_byteenable[0]
    |=> mask_ff == $past(avs_writedata[0])) else $error("mask write lost");
  ctrl_rd_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req && avs_read && avs_address == cmp_pkg::ctrl_off |=> avs_readdata == $past(ctrl_ff))
    else $error("control read wrong");
  refset_rd_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req && avs_read && avs_address == cmp_pkg::refset_off
    |=> avs_readdata[cmp_pkg::refset_w-1:0] == $past(refset_ff)) else $error("reference read wrong");
  status_rd_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req && avs_read && avs_address == cmp_pkg::status_off |=> avs_readdata[0] == $past(pend_ff && mask_ff))
    else $error("masked status wrong");
  raw_rd_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req && avs_read && avs_address == cmp_pkg::raw_off |=> avs_readdata[0] == $past(pend_ff))
    else $error("raw status wrong");
  value_rd_a: assert property (@(posedge mclk) disable iff (!rst_n)
    req && avs_read && avs_address == cmp_pkg::value_off |=> avs_readdata[0] == $past(cur))
    else $error("comparator value wrong");

  // ****************************************
  // Coverage
  // ****************************************
  trig_seen_c: cover property (@(posedge mclk) disable iff (!rst_n) adc_trigger);
  irq_seen_c:  cover property (@(posedge mclk) disable iff (!rst_n) irq);
  clr_seen_c:  cover property (@(posedge mclk) disable iff (!rst_n) irq ##1 clr_wr ##2 !irq);
  hold_seen_c: cover property (@(posedge mclk) disable iff (!rst_n) clr_wr && int_hit);
  inv_seen_c:  cover property (@(posedge mclk) disable iff (!rst_n) ctrl_ff[cmp_pkg::inv_bit] && cmp_pin_out);

endmodule

// ==== dv/adc_irq_sink.sv ====
/*
  Far-side model: the ADC trigger input, counting trigger events.
  Assumes one mclk domain; the bench pulses clr between windows.
*/
`timescale 1ns/1ps
module adc_irq_sink
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       clr,
  input  wire logic       adc_trigger,
  output logic      [7:0] trig_events
);
  logic trig_ff;

  // Rising edges only, so a level and a pulse both count once
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trig_ff     <= 1'b0;
      trig_events <= 8'h00;
    end
    else
    begin
      trig_ff     <= adc_trigger;
      trig_events <= clr ? 8'h00 : trig_events + {7'h00, adc_trigger & !trig_ff};
    end
  end
endmodule

// ==== dv/tb_comparator_event_logic.sv ====
/*
  Self-checking bench for the comparator event logic.
  Assumes an Avalon-MM slave that answers through waitrequest and a
  comparator path of a few registered stages.
*/
`timescale 1ns/1ps
module tb_comparator_event_logic;
  logic        mclk = 1'b0;
  logic        rst_n, avs_read, avs_write, cmp_raw, clr;
  logic        cmp_pin_out, ref_enable, adc_trigger, irq, avs_waitrequest;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_v;
  logic [1:0]  ref_select;
  logic [4:0]  ref_level;
  logic [7:0]  trig_events;
  int          miscompares, tests_run;

  always #25 mclk = ~mclk;

  cmp_event DUT (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cmp_raw(cmp_raw),
    .cmp_pin_out(cmp_pin_out), .ref_select(ref_select), .ref_level(ref_level),
    .ref_enable(ref_enable), .adc_trigger(adc_trigger), .irq(irq));
  adc_irq_sink sink (.mclk(mclk), .rst_n(rst_n), .clr(clr), .adc_trigger(adc_trigger),
    .trig_events(trig_events));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd_v = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50)
    begin
      miscompares++;
      give_verdict();
    end
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd_v, exp);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rdchk(cmp_pkg::ctrl_off, cmp_pkg::ctrl_rst);
    rdchk(cmp_pkg::refset_off, {27'h0, cmp_pkg::refset_rst});
    bus(1'b1, 6'h18, 32'hffff_ffff);
    rdchk(6'h18, cmp_pkg::unmapped_rd);
    rdchk(cmp_pkg::ctrl_off, cmp_pkg::ctrl_rst);
    chk({31'h0, irq}, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_ref;
    logic [1:0] src [3];
    src = '{cmp_pkg::ref_from_own_pin, cmp_pkg::ref_from_first_unit_pin, cmp_pkg::ref_from_internal_source};
    foreach (src[i])
    begin
      bus(1'b1, cmp_pkg::ctrl_off, 32'(src[i]) << cmp_pkg::src_lsb);
      cyc(2);
      chk({30'h0, ref_select}, {30'h0, src[i]});
    end
    bus(1'b1, cmp_pkg::refset_off, 32'h1f);
    cyc(2);
    chk({26'h0, ref_enable, ref_level}, 32'h3f);
    bus(1'b1, cmp_pkg::refset_off, 32'h0);
    cyc(2);
    chk({31'h0, ref_enable}, 32'h0);
    $display("test reference done");
  endtask

  task automatic t_pol;
    for (int inv = 0; inv < 2; inv++)
      for (int v = 0; v < 2; v++)
      begin
        bus(1'b1, cmp_pkg::ctrl_off, 32'(inv) << cmp_pkg::inv_bit);
        cmp_raw <= v[0];
        cyc(6);
        chk({31'h0, cmp_pin_out}, 32'(v ^ inv));
        rdchk(cmp_pkg::value_off, 32'(v));
      end
    $display("test polarity done");
  endtask

  // One rise then one fall of the comparator in every mode, off included
  task automatic t_modes;
    logic [2:0] md [6];
    int mc [6] = '{0, 1, 0, 0, 1, 1};
    int fc [6] = '{0, 1, 1, 1, 1, 2};
    int ml [6] = '{0, 1, 0, 0, 0, 0};
    int fl [6] = '{0, 0, 1, 0, 0, 0};
    int mr [6] = '{0, 1, 1, 0, 1, 1};
    int fr [6] = '{0, 1, 1, 1, 0, 1};
    md = '{cmp_pkg::adc_trigger_off, cmp_pkg::adc_trigger_level_high, cmp_pkg::adc_trigger_level_low,
      cmp_pkg::adc_trigger_falling_edge, cmp_pkg::adc_trigger_rising_edge, cmp_pkg::adc_trigger_any_edge};
    foreach (md[i])
    begin
      bus(1'b1, cmp_pkg::ctrl_off, (32'(md[i]) << cmp_pkg::trig_lsb) | (32'(md[i]) << cmp_pkg::int_lsb));
      cyc(6);
      bus(1'b1, cmp_pkg::status_off, 32'h1);
      clr <= 1'b1;
      cyc(1);
      clr     <= 1'b0;
      cmp_raw <= 1'b1;
      cyc(6);
      chk({24'h0, trig_events}, 32'(mc[i]));
      chk({31'h0, adc_trigger}, 32'(ml[i]));
      rdchk(cmp_pkg::raw_off, 32'(mr[i]));
      bus(1'b1, cmp_pkg::status_off, 32'h1);
      cmp_raw <= 1'b0;
      cyc(6);
      chk({24'h0, trig_events}, 32'(fc[i]));
      chk({31'h0, adc_trigger}, 32'(fl[i]));
      rdchk(cmp_pkg::raw_off, 32'(fr[i]));
    end
    $display("test modes done");
  endtask

  // Interrupt on rise, then mask and clear, then trigger on fall
  task automatic t_irq;
    int n;
    bus(1'b1, cmp_pkg::ctrl_off, (32'(cmp_pkg::adc_trigger_falling_edge) << cmp_pkg::trig_lsb)
      | (32'(cmp_pkg::adc_trigger_rising_edge) << cmp_pkg::int_lsb));
    bus(1'b1, cmp_pkg::mask_off, 32'h1);
    bus(1'b1, cmp_pkg::status_off, 32'h1);
    clr <= 1'b1;
    cyc(1);
    clr     <= 1'b0;
    cmp_raw <= 1'b1;
    n = 0;
    while (irq !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    chk(32'(n < 20), 32'h1);
    if (n >= 20)
      give_verdict();
    chk({24'h0, trig_events}, 32'h0);
    rdchk(cmp_pkg::status_off, 32'h1);
    bus(1'b1, cmp_pkg::mask_off, 32'h0);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    rdchk(cmp_pkg::status_off, 32'h0);
    rdchk(cmp_pkg::raw_off, 32'h1);
    bus(1'b1, cmp_pkg::mask_off, 32'h1);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, cmp_pkg::status_off, 32'h1);
    cyc(1);
    chk({31'h0, irq}, 32'h0);
    cmp_raw <= 1'b0;
    cyc(6);
    chk({24'h0, trig_events}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    $display("test interrupt done");
  endtask

  initial
  begin
    rst_n         = 1'b0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_address   = 6'h00;
    avs_writedata = 32'h0;
    cmp_raw       = 1'b0;
    clr           = 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_ref();
    t_pol();
    t_modes();
    t_irq();
    give_verdict();
  end
endmodule
